//--- rtl/pcp_claim_pending_regs.sv
/*
 Pending, enable, level, threshold, vector table, handler pointer,
 claim trigger and claimed-level registers of the external interrupt
 controller. Assumes gateways deliver one pending level per source,
 synchronous to i_clk, and that the core issues word-sized accesses.
*/
`timescale 1ns/1ps
// Summary of operation
// - Eight pending words, bit Y of word X is source X*32+Y; bit0 word0 zero.
// - Pending words are read-only, writes ignored, reset to zero.
// - Per-source enable: bit 0 enables, resets 0, upper bits read 0.
// - Notify only enabled pending sources strictly above the threshold.
// - Threshold masks levels at or below it in the chosen order.
// - Threshold and claimed level read and write inverted in reverse order.
// - Vector table base holds bits 31:10, resets 0, low bits read 0.
// - Handler pointer upper field follows the vector base directly.
// - Handler pointer holds captured winner ID at 9:2, bits 1:0 zero.
// - Equal-priority tie goes to the lowest source ID.
// - Winner is searched every cycle and always ready for capture.
// - Claim trigger write captures winner ID and level together.
// - Claim trigger has no storage and reads zero.
// - Handler pointer is read-only and resets to zero.
// - Claimed level holds 4 bits, loaded on claim, writable, resets 0.
// - Configuration bit picks standard or reverse priority order.
// - Each source has a 4-bit level; the lowest level never interrupts.
// - Notify also needs priority strictly above the current handler level.
module pcp_claim_pending_regs
    import pcp_pkg::*;
#(
    parameter int NSRC = 255
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // CSR port from the core
    input wire logic i_csr_wr,
    input wire logic [CSR_AW-1:0] i_csr_addr,
    input wire logic [WORD_W-1:0] i_csr_wdata,
    output logic [WORD_W-1:0] o_csr_rdata,
    // Memory-mapped port from the core
    input wire logic i_mm_wr,
    input wire logic [MM_AW-1:0] i_mm_addr,
    input wire logic [WORD_W-1:0] i_mm_wdata,
    output logic [WORD_W-1:0] o_mm_rdata,
    // Gateway pending levels
    input wire logic [NSRC:1] i_src_pending,
    // Notification to the core
    output logic o_ext_int
);

    // Stored state
    logic [NSRC:1][3:0] prio_q;
    logic [NSRC:1] en_q;
    logic [NSRC:1] pend_q;
    logic order_q;
    logic [3:0] thresh_q;
    logic [3:0] curpl_q;
    logic [BASE_W-1:0] base_q;
    logic [7:0] claim_id_q;
    logic [3:0] claim_prio_q;
    logic int_q;
    logic [WORD_W-1:0] csr_rdata_q;
    logic [WORD_W-1:0] mm_rdata_q;

    // Decode helpers
    logic [9:0] mm_idx;
    logic mm_idx_ok;
    logic [2:0] mm_region;
    logic csr_claim;
    logic [PEND_BITS-1:0] pend_full;
    logic [WORD_W-1:0] csr_rdata_d;
    logic [WORD_W-1:0] mm_rdata_d;
    logic int_d;

    pcp_arb_if #(.NSRC(NSRC)) arb_bus ();

    // Source index valid only for 1..NSRC
    function automatic logic idx_in_range(input logic [9:0] idx);
        return (idx != 10'h0) && (int'(idx) <= NSRC);
    endfunction

    // Address decode for the memory-mapped side and the CSR claim trigger
    assign mm_idx = i_mm_addr[11:2];
    assign mm_idx_ok = idx_in_range(mm_idx);
    assign mm_region = i_mm_addr[14:12];
    assign csr_claim = i_csr_wr && (i_csr_addr == CSR_CLAIM);

    // Feed the winner search; enables gate only here
    assign arb_bus.req = pend_q & en_q;
    assign arb_bus.level = prio_q;

    pcp_arbiter #(
        .NSRC(NSRC)
    ) u_arbiter (
        .arb(arb_bus)
    );

    // Sample gateway levels; no write path exists here
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pend_q <= '0;
        end else begin
            pend_q <= i_src_pending;
        end
    end

    // Pending words laid out flat with bit 0 of word 0 held at zero
    always_comb begin
        pend_full = '0;
        pend_full[NSRC:1] = pend_q;
    end

    // Priority order selection bit
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            order_q <= ORDER_RST;
        end else if (i_mm_wr && (i_mm_addr == MM_CFG)) begin
            order_q <= i_mm_wdata[0];
        end
    end

    // Per-source levels, kept in internal order so 0 never wins
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prio_q <= '0;
        end else if (i_mm_wr && (mm_region == MM_PRIO_BASE[14:12]) && mm_idx_ok) begin
            prio_q[mm_idx] <= pcp_xlate(i_mm_wdata[3:0], order_q);
        end
    end

    // Per-source enables
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            en_q <= '0;
        end else if (i_mm_wr && (mm_region == MM_EN_BASE[14:12]) && mm_idx_ok) begin
            en_q[mm_idx] <= i_mm_wdata[0];
        end
    end

    // Threshold; the write path inverts in reverse order
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            thresh_q <= PRIO_RST;
        end else if (i_csr_wr && (i_csr_addr == CSR_THRESH)) begin
            thresh_q <= pcp_xlate(i_csr_wdata[3:0], order_q);
        end
    end

    // Current handler level, owned by firmware
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            curpl_q <= PRIO_RST;
        end else if (i_csr_wr && (i_csr_addr == CSR_CUR_LEVEL)) begin
            curpl_q <= pcp_xlate(i_csr_wdata[3:0], order_q);
        end
    end

    // Vector table base; low ten bits have no storage
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            base_q <= BASE_RST;
        end else if (i_csr_wr && (i_csr_addr == CSR_VECT_BASE)) begin
            base_q <= i_csr_wdata[WORD_W-1:BASE_LSB];
        end
    end

    // Claim snapshot: ID and level come from the same winner cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            claim_id_q <= ID_RST;
        end else if (csr_claim) begin
            claim_id_q <= arb_bus.win_id;
        end
    end

    // Claimed level: loaded by a claim, also directly writable
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            claim_prio_q <= PRIO_RST;
        end else if (csr_claim) begin
            claim_prio_q <= arb_bus.win_prio;
        end else if (i_csr_wr && (i_csr_addr == CSR_CLAIM_PRIO)) begin
            claim_prio_q <= pcp_xlate(i_csr_wdata[3:0], order_q);
        end
    end

    // Notification; internal order makes one compare serve both orders
    always_comb begin
        int_d = (arb_bus.win_id != ID_RST)
            && (arb_bus.win_prio > thresh_q)
            && (arb_bus.win_prio > curpl_q);
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            int_q <= 1'b0;
        end else begin
            int_q <= int_d;
        end
    end

    // CSR read mux; unknown numbers read zero
    always_comb begin
        csr_rdata_d = '0;
        case (i_csr_addr)
            CSR_VECT_BASE: begin
                csr_rdata_d = {base_q, 10'h0};
            end
            CSR_THRESH: begin
                csr_rdata_d[3:0] = pcp_xlate(thresh_q, order_q);
            end
            CSR_CLAIM: begin
                csr_rdata_d = '0;
            end
            CSR_CLAIM_PRIO: begin
                csr_rdata_d[3:0] = pcp_xlate(claim_prio_q, order_q);
            end
            CSR_CUR_LEVEL: begin
                csr_rdata_d[3:0] = pcp_xlate(curpl_q, order_q);
            end
            CSR_HANDLER_PTR: begin
                csr_rdata_d = {base_q, claim_id_q, 2'b00};
            end
            default: begin
                csr_rdata_d = '0;
            end
        endcase
    end

    // Memory-mapped read mux; holes read zero, writes to them drop
    always_comb begin
        mm_rdata_d = '0;
        case (mm_region)
            MM_PRIO_BASE[14:12]: begin
                if (mm_idx_ok) begin
                    mm_rdata_d[3:0] = pcp_xlate(prio_q[mm_idx], order_q);
                end
            end
            MM_PEND_BASE[14:12]: begin
                if (i_mm_addr[11:5] == 7'h0) begin
                    mm_rdata_d = pend_full[i_mm_addr[4:2]*WORD_W +: WORD_W];
                end
            end
            MM_EN_BASE[14:12]: begin
                if (mm_idx_ok) begin
                    mm_rdata_d[0] = en_q[mm_idx];
                end
            end
            MM_CFG[14:12]: begin
                if (i_mm_addr[11:0] == 12'h0) begin
                    mm_rdata_d[0] = order_q;
                end
            end
            default: begin
                mm_rdata_d = '0;
            end
        endcase
    end

    // Read data registered: valid one cycle after the address
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            csr_rdata_q <= '0;
            mm_rdata_q <= '0;
        end else begin
            csr_rdata_q <= csr_rdata_d;
            mm_rdata_q <= mm_rdata_d;
        end
    end

    assign o_csr_rdata = csr_rdata_q;
    assign o_mm_rdata = mm_rdata_q;
    assign o_ext_int = int_q;

    // Checks run on the core clock and stop during reset
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    claim_id_snap_a: assert property (
        csr_claim |=> claim_id_q == $past(arb_bus.win_id))
        else $error("claim ID not captured from winner");

    claim_prio_snap_a: assert property (
        csr_claim |=> claim_prio_q == $past(arb_bus.win_prio))
        else $error("claimed level not captured from winner");

    ptr_id_field_a: assert property (
        $past(i_csr_addr) == CSR_HANDLER_PTR
        |-> (o_csr_rdata[9:2] == $past(claim_id_q)) && (o_csr_rdata[1:0] == 2'b00))
        else $error("handler pointer ID field wrong");

    ptr_base_follow_a: assert property (
        $past(i_csr_addr) == CSR_HANDLER_PTR
        |-> o_csr_rdata[31:10] == $past(base_q))
        else $error("handler pointer base does not follow vector base");

    trigger_reads_zero_a: assert property (
        $past(i_csr_addr) == CSR_CLAIM |-> o_csr_rdata == '0)
        else $error("claim trigger read nonzero");

    notify_gate_a: assert property (
        o_ext_int |-> ($past(arb_bus.win_prio) > $past(thresh_q))
            && ($past(arb_bus.win_prio) > $past(curpl_q)))
        else $error("notification without exceeding threshold");

    winner_valid_a: assert property (
        arb_bus.win_id != ID_RST |-> arb_bus.req[arb_bus.win_id]
            && (prio_q[arb_bus.win_id] == arb_bus.win_prio))
        else $error("winner not an enabled pending source");

    pend_readonly_a: assert property (
        i_mm_wr && (mm_region == MM_PEND_BASE[14:12])
        |=> pend_q == $past(i_src_pending))
        else $error("pending status changed by a write");

    base_low_zero_a: assert property (
        $past(i_csr_addr) == CSR_VECT_BASE |-> o_csr_rdata[9:0] == 10'h0)
        else $error("vector base low bits nonzero");

    enable_upper_zero_a: assert property (
        $past(mm_region) == MM_EN_BASE[14:12] |-> o_mm_rdata[31:1] == '0)
        else $error("enable register upper bits nonzero");

    pend_bit0_zero_a: assert property (
        ($past(mm_region) == MM_PEND_BASE[14:12]) && ($past(i_mm_addr[11:2]) == 10'h0)
        |-> o_mm_rdata[0] == 1'b0)
        else $error("reserved pending bit nonzero");

    notify_raise_a: assert property (
        ($past(arb_bus.win_id) != ID_RST) && ($past(arb_bus.win_prio) > $past(thresh_q))
            && ($past(arb_bus.win_prio) > $past(curpl_q))
        |-> o_ext_int)
        else $error("qualifying source not notified");

    level_upper_zero_a: assert property (
        $past(i_csr_addr) == CSR_CLAIM_PRIO |-> o_csr_rdata[31:4] == '0)
        else $error("claimed level upper bits nonzero");

    // Main scenarios
    claim_winner_c: cover property (csr_claim && (arb_bus.win_id != ID_RST));
    notify_c: cover property (!o_ext_int ##1 o_ext_int);
    reverse_order_c: cover property (order_q && o_ext_int);
    tie_c: cover property (arb_bus.req[1] && arb_bus.req[2]
        && (prio_q[1] == prio_q[2]) && (arb_bus.win_id == 8'h01));

endmodule

//--- rtl/pcp_pkg.sv
/*
 Constants, register map and shared helpers of the interrupt claim and
 pending register block. Assumes one core clock and a word-aligned
 memory-mapped port plus a CSR port driven by the core.
*/
package pcp_pkg;

    // Field widths
    localparam int PRIO_W = 4;
    localparam int ID_W = 8;
    localparam int WORD_W = 32;
    localparam int PEND_WORDS = 8;
    localparam int PEND_BITS = PEND_WORDS * WORD_W;
    localparam int CSR_AW = 12;
    localparam int MM_AW = 15;

    // CSR numbers
    localparam logic [11:0] CSR_VECT_BASE = 12'hbc8;
    localparam logic [11:0] CSR_THRESH = 12'hbc9;
    localparam logic [11:0] CSR_CLAIM = 12'hbca;
    localparam logic [11:0] CSR_CLAIM_PRIO = 12'hbcb;
    localparam logic [11:0] CSR_CUR_LEVEL = 12'hbcc;
    localparam logic [11:0] CSR_HANDLER_PTR = 12'hfc8;

    // Memory-mapped offsets; level and enable of source S sit at base + S*4
    localparam logic [14:0] MM_PRIO_BASE = 15'h0000;
    localparam logic [14:0] MM_PEND_BASE = 15'h1000;
    localparam logic [14:0] MM_EN_BASE = 15'h2000;
    localparam logic [14:0] MM_CFG = 15'h3000;

    // Field positions
    localparam int BASE_LSB = 10;
    localparam int ID_LSB = 2;
    localparam int BASE_W = WORD_W - BASE_LSB;

    // Reset values
    localparam logic [3:0] PRIO_RST = 4'h0;
    localparam logic [21:0] BASE_RST = 22'h0;
    localparam logic [7:0] ID_RST = 8'h0;
    localparam logic EN_RST = 1'b0;
    localparam logic ORDER_RST = 1'b0;

    typedef logic [PRIO_W-1:0] pcp_prio_type;

    // Core-side view of a level: inverted in reverse order
    function automatic pcp_prio_type pcp_xlate(input pcp_prio_type v, input logic rev);
        return v ^ {PRIO_W{rev}};
    endfunction

endpackage

//--- rtl/pcp_arb_if.sv
/*
 Carrier between the register block and the winner search.
 Assumes both ends sit in the same core clock domain.
*/
`timescale 1ns/1ps
interface pcp_arb_if #(
    parameter int NSRC = 255
);
    // Requests and levels in internal order (higher wins, 0 never)
    logic [NSRC:1] req;
    logic [NSRC:1][3:0] level;
    // Current winner, 0 when nobody qualifies
    logic [7:0] win_id;
    logic [3:0] win_prio;

    modport arb (input req, input level, output win_id, output win_prio);
    modport ctl (output req, output level, input win_id, input win_prio);
endinterface

//--- rtl/pcp_arbiter.sv
/*
 Combinational search for the highest-priority enabled pending source.
 Assumes levels arrive already in internal order, where 0 never wins.
*/
`timescale 1ns/1ps
module pcp_arbiter
    import pcp_pkg::*;
#(
    parameter int NSRC = 255
) (
    // Requests in, winner out
    pcp_arb_if.arb arb
);

    // Ascending scan with strict compare keeps the lowest ID on ties
    always_comb begin
        logic [7:0] best_id;
        logic [3:0] best_p;
        best_id = ID_RST;
        best_p = PRIO_RST;
        for (int s = 1; s <= NSRC; s++) begin
            if (arb.req[s] && (arb.level[s] > best_p)) begin
                best_p = arb.level[s];
                best_id = 8'(s);
            end
        end
        arb.win_id = best_id;
        arb.win_prio = best_p;
    end

endmodule

//--- bench/pcp_src_model.sv
/*
 Interrupt sources as seen through their gateways.
 Assumes the bench loads a new level pattern with a one-cycle strobe.
*/
`timescale 1ns/1ps
module pcp_src_model #(
    parameter int NSRC = 40
) (
    // Clock, reset and load
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_load,
    input wire logic [NSRC:1] i_pattern,
    // Levels toward the block
    output logic [NSRC:1] o_src_pending
);
    // Levels move only on an edge, as synchronised gateway outputs do
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_src_pending <= '0;
        end else if (i_load) begin
            o_src_pending <= i_pattern;
        end
    end
endmodule

//--- bench/tb_top.sv
/*
 Self-checking bench for the claim and pending register block.
 Assumes one-cycle registered read data on both core ports.
*/
`timescale 1ns/1ps
module tb_top;
    import pcp_pkg::*;
    localparam int NS = 40;
    localparam logic [11:0] csr_list [7] = '{CSR_VECT_BASE, CSR_THRESH, CSR_CLAIM,
        CSR_CLAIM_PRIO, CSR_CUR_LEVEL, CSR_HANDLER_PTR, 12'h7c0};
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_csr_wr = 1'b0;
    logic [11:0] i_csr_addr = 12'h0;
    logic [31:0] i_csr_wdata = 32'h0;
    logic i_mm_wr = 1'b0;
    logic [14:0] i_mm_addr = 15'h0;
    logic [31:0] i_mm_wdata = 32'h0;
    logic [NS:1] src_pending;
    logic [31:0] o_csr_rdata;
    logic [31:0] o_mm_rdata;
    logic o_ext_int;
    logic ld = 1'b0;
    logic [NS:1] pat = '0;
    logic [1:0] chk_kind = 2'h0;
    logic [31:0] exp_q [$];
    logic [3:0] lev [NS:1];
    logic [NS:1] en;
    logic [31:0] base;
    int error_cnt = 0;
    int tests_run = 0;
    integer seed = 32'h4235d667;

    always #2.5 i_clk = ~i_clk;

    pcp_src_model #(.NSRC(NS)) i_src (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_load(ld),
        .i_pattern(pat), .o_src_pending(src_pending));
    pcp_claim_pending_regs #(.NSRC(NS)) i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_csr_wr(i_csr_wr), .i_csr_addr(i_csr_addr), .i_csr_wdata(i_csr_wdata),
        .o_csr_rdata(o_csr_rdata), .i_mm_wr(i_mm_wr), .i_mm_addr(i_mm_addr),
        .i_mm_wdata(i_mm_wdata), .o_mm_rdata(o_mm_rdata), .i_src_pending(src_pending),
        .o_ext_int(o_ext_int));

    task automatic finish_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One compare per kind of result; an unknown on either side is a mismatch
    task automatic cmp_csr(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t csr got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_mm(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t mm got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_int(input logic got, input logic [31:0] exp);
        tests_run++;
        if ({31'h0, got} !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t int got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic csr_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_csr_wr <= 1'b1;
        i_csr_addr <= a;
        i_csr_wdata <= d;
        @(posedge i_clk);
        i_csr_wr <= 1'b0;
    endtask

    task automatic mm_wr(input logic [14:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_mm_wr <= 1'b1;
        i_mm_addr <= a;
        i_mm_wdata <= d;
        @(posedge i_clk);
        i_mm_wr <= 1'b0;
    endtask

    // Kind 1 CSR read, 2 mapped read, 3 notification level
    task automatic expect_rd(input logic [1:0] k, input logic [14:0] a, input logic [31:0] d);
        @(posedge i_clk);
        if (k == 2'h1) i_csr_addr <= a[11:0];
        else if (k == 2'h2) i_mm_addr <= a;
        chk_kind <= k;
        exp_q.push_back(d);
        @(posedge i_clk);
        chk_kind <= 2'h0;
    endtask

    // Read data lands one edge after its address, so the oldest note is due
    always @(posedge i_clk) begin
        logic [1:0] k;
        k = chk_kind;
        #1;
        if (k == 2'h1) cmp_csr(o_csr_rdata, exp_q.pop_front());
        if (k == 2'h2) cmp_mm(o_mm_rdata, exp_q.pop_front());
        if (k == 2'h3) cmp_int(o_ext_int, exp_q.pop_front());
    end

    // Expected winner in internal order; strict compare keeps the lowest ID
    function automatic logic [11:0] best(input logic rev);
        logic [3:0] bl;
        logic [7:0] bi;
        bl = 4'h0;
        bi = 8'h0;
        for (int s = 1; s <= NS; s++) begin
            if (pat[s] && en[s] && ((lev[s] ^ {4{rev}}) > bl)) begin
                bl = lev[s] ^ {4{rev}};
                bi = 8'(s);
            end
        end
        return {bi, bl};
    endfunction

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge i_clk);
        error_cnt++;
        finish_test();
    end

    initial begin
        logic [11:0] w;
        logic [3:0] thr;
        logic [3:0] cur;
        logic rev;
        logic [31:0] r;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        // Reset values, the storage-free trigger and an unmapped number
        for (int j = 0; j < 7; j++) begin
            expect_rd(2'h1, 15'(csr_list[j]), 32'h0);
        end
        for (int j = 0; j < 8; j++) begin
            expect_rd(2'h2, 15'(MM_PEND_BASE + j * 4), 32'h0);
        end
        expect_rd(2'h2, 15'(MM_EN_BASE + 4), 32'h0);
        csr_wr(CSR_VECT_BASE, 32'hffffffff);
        expect_rd(2'h1, 15'(CSR_VECT_BASE), 32'hfffffc00);
        csr_wr(CSR_HANDLER_PTR, 32'h3ff);
        expect_rd(2'h1, 15'(CSR_HANDLER_PTR), 32'hfffffc00);
        csr_wr(CSR_CLAIM, 32'hffffffff);
        expect_rd(2'h1, 15'(CSR_CLAIM), 32'h0);
        csr_wr(CSR_CLAIM_PRIO, 32'hfffffff7);
        expect_rd(2'h1, 15'(CSR_CLAIM_PRIO), 32'h7);
        mm_wr(15'(MM_EN_BASE + 4), 32'hffffffff);
        expect_rd(2'h2, 15'(MM_EN_BASE + 4), 32'h1);
        expect_rd(2'h2, 15'(MM_EN_BASE + (NS + 1) * 4), 32'h0);
        // Random rounds in both orders; the last one is an all-way tie
        for (int i = 0; i < 8; i++) begin
            rev = i[0];
            mm_wr(MM_CFG, {31'h0, rev});
            base = $random(seed);
            csr_wr(CSR_VECT_BASE, base);
            for (int s = 1; s <= NS; s++) begin
                r = $random(seed);
                lev[s] = (i == 7) ? (4'h9 ^ {4{rev}}) : r[3:0];
                en[s] = r[4];
                mm_wr(15'(MM_PRIO_BASE + s * 4), {28'h0, lev[s]});
                mm_wr(15'(MM_EN_BASE + s * 4), {31'h0, en[s]});
            end
            @(posedge i_clk);
            pat <= NS'({$random(seed), $random(seed)});
            ld <= 1'b1;
            @(posedge i_clk);
            ld <= 1'b0;
            r = $random(seed);
            thr = (i < 2) ? {4{rev}} : ((i < 4) ? ~{4{rev}} : r[3:0]);
            cur = (i < 6) ? {4{rev}} : r[7:4];
            csr_wr(CSR_THRESH, {28'h0, thr});
            csr_wr(CSR_CUR_LEVEL, {28'h0, cur});
            repeat (3) @(posedge i_clk);
            w = best(rev);
            expect_rd(2'h3, 15'h0, {31'h0, (w[3:0] > (thr ^ {4{rev}}))
                && (w[3:0] > (cur ^ {4{rev}}))});
            expect_rd(2'h1, 15'(CSR_THRESH), {28'h0, thr});
            expect_rd(2'h1, 15'(CSR_CUR_LEVEL), {28'h0, cur});
            expect_rd(2'h2, MM_CFG, {31'h0, rev});
            mm_wr(MM_PEND_BASE, 32'hffffffff);
            for (int j = 0; j < 8; j++) begin
                expect_rd(2'h2, 15'(MM_PEND_BASE + j * 4), 32'({pat, 1'b0} >> (j * 32)));
            end
            // Firmware claims first, then reads the pointer
            csr_wr(CSR_CLAIM, r);
            expect_rd(2'h1, 15'(CSR_HANDLER_PTR), {base[31:10], w[11:4], 2'b00});
            expect_rd(2'h1, 15'(CSR_CLAIM_PRIO), {28'h0, w[3:0] ^ {4{rev}}});
            expect_rd(2'h2, 15'(MM_PRIO_BASE + 4), {28'h0, lev[1]});
            csr_wr(CSR_VECT_BASE, ~base);
            expect_rd(2'h1, 15'(CSR_HANDLER_PTR), {~base[31:10], w[11:4], 2'b00});
        end
        finish_test();
    end
endmodule
